// ### rsc_top.sv
`default_nettype none

//Contract
// - an operation with no memory answer in 30 ms is abandoned, back to idle
// - time-out sets status bit 10; software clears it by writing one
// - data-in line high with no memory: nothing times out, busy clears at end
// - data-in line low with no memory: only erase/write commands may time out
// - load-complete bit 9 set after a valid image load; write one to clear
// - 9-bit byte address in bits 8:0 addresses the memory, resets to zero
// - data register at 034h holds last read byte or byte to write in 7:0
// - writing one to bit 31 starts the command; it self-clears when done
// - command field 30:28 selects read, lock, unlock, write, fills, erases, refetch
// - refetch fails without A5h at location zero and changes nothing
// - busy reads set from reset until the initial image load finishes
module rsc_top #(
    parameter int unsigned TIMEOUT_CYCLES = rsc_pkg::TIMEOUT_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             rom_select,
    output logic             rom_serial_clock,
    output logic             rom_serial_output_line,
    input  wire logic        rom_serial_input_line
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ISSUE = 3'b010,
        ST_WAIT  = 3'b100
    } rsc_ctl_state_e;

    rsc_eng_if eng ();

    rsc_ctl_state_e    state_q;
    logic              boot_q;
    logic              busy_q;
    logic              timeout_q;
    logic              loaded_q;
    rsc_pkg::rsc_cmd_t cmd_q;
    logic [8:0]        addr_q;
    logic [7:0]        data_q;
    logic [31:0]       prdata_q;

    // bus decode
    wire setup_ph  = psel & ~penable;
    wire access_ph = psel & penable;
    wire hit_cmd   = (paddr == rsc_pkg::CMD_STATUS_OFF);
    wire hit_data  = (paddr == rsc_pkg::DATA_BYTE_OFF);
    wire hit_any   = hit_cmd | hit_data;
    wire wr_cmd    = access_ph & pwrite & hit_cmd;
    wire wr_data   = access_ph & pwrite & hit_data;

    // command and data are frozen while an operation runs
    wire accept_cmd  = wr_cmd & ~busy_q;
    wire accept_data = wr_data & ~busy_q;
    wire go          = accept_cmd & pwdata[rsc_pkg::BUSY_BIT];

    // operation in flight: the boot load is a refetch
    wire rsc_pkg::rsc_cmd_t op_cmd = boot_q ? rsc_pkg::CMD_REFETCH : cmd_q;
    wire finish      = (state_q == ST_WAIT) & eng.done;
    wire op_is_read  = (op_cmd == rsc_pkg::CMD_READ);
    wire op_is_fetch = (op_cmd == rsc_pkg::CMD_REFETCH);
    wire image_ok    = (eng.rx_byte == rsc_pkg::IMAGE_SIG);

    wire set_timeout = finish & eng.timed_out;
    wire clr_timeout = wr_cmd & pwdata[rsc_pkg::TIMEOUT_BIT];
    wire set_loaded  = finish & op_is_fetch & ~eng.timed_out & image_ok;
    wire clr_loaded  = wr_cmd & pwdata[rsc_pkg::LOADED_BIT];
    wire take_rx     = finish & op_is_read & ~eng.timed_out;

    // engine request
    assign eng.start      = (state_q == ST_ISSUE);
    assign eng.frame      = rsc_pkg::build_frame(op_cmd, addr_q, data_q);
    assign eng.nbits      = rsc_pkg::frame_len(op_cmd);
    assign eng.wait_ready = rsc_pkg::may_time_out(op_cmd);

    // read views
    wire [31:0] cmd_view  = {busy_q, cmd_q, 17'h00000, timeout_q, loaded_q, addr_q};
    wire [31:0] data_view = {24'h000000, data_q};
    wire [31:0] rd_mux    = hit_cmd  ? cmd_view  :
                            hit_data ? data_view : 32'h00000000;

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = access_ph & ~hit_any;

    rsc_shift_engine #(
        .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
    ) u_engine (
        .pclk                   (pclk),
        .presetn                (presetn),
        .eng                    (eng.engine),
        .rom_select             (rom_select),
        .rom_serial_clock       (rom_serial_clock),
        .rom_serial_output_line (rom_serial_output_line),
        .rom_serial_input_line  (rom_serial_input_line)
    );

    // control sequence; boot load starts straight out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_ISSUE;
            boot_q  <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (go) begin
                        state_q <= ST_ISSUE;
                    end
                end
                ST_ISSUE: state_q <= ST_WAIT;
                ST_WAIT: begin
                    if (eng.done) begin
                        state_q <= ST_IDLE;
                        boot_q  <= 1'b0;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // busy: set at reset and on start, cleared only at completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b1;
        end else if (go) begin
            busy_q <= 1'b1;
        end else if (finish) begin
            busy_q <= 1'b0;
        end
    end

    // sticky flags: a set in the same cycle as the clear wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_q <= 1'b0;
            loaded_q  <= 1'b0;
        end else begin
            timeout_q <= set_timeout | (timeout_q & ~clr_timeout);
            loaded_q  <= set_loaded | (loaded_q & ~clr_loaded);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q  <= rsc_pkg::CMD_RST;
            addr_q <= rsc_pkg::ADDR_RST;
        end else if (accept_cmd) begin
            cmd_q  <= pwdata[rsc_pkg::CMD_MSB:rsc_pkg::CMD_LSB];
            addr_q <= pwdata[rsc_pkg::ADDR_MSB:0];
        end
    end

    // refetch never touches the data byte, pass or fail
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= rsc_pkg::DATA_RST;
        end else if (take_rx) begin
            data_q <= eng.rx_byte;
        end else if (accept_data) begin
            data_q <= pwdata[rsc_pkg::DATA_MSB:0];
        end
    end

    // read data captured in the setup phase, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (setup_ph) begin
            prdata_q <= rd_mux;
        end
    end
endmodule // rsc_top

`default_nettype wire

// ### rsc_pkg.sv
`default_nettype none

package rsc_pkg;

    // clock and serial timing
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned TIMEOUT_MS    = 30;
    localparam int unsigned TIMEOUT_CYC   = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned SK_HALF_NS    = 1000;
    localparam int unsigned SK_HALF_CYC   = SK_HALF_NS / CLK_PERIOD_NS;

    // register map (byte addresses)
    localparam logic [11:0] CMD_STATUS_OFF = 12'h030;
    localparam logic [11:0] DATA_BYTE_OFF  = 12'h034;

    // field positions
    localparam int BUSY_BIT    = 31;
    localparam int CMD_MSB     = 30;
    localparam int CMD_LSB     = 28;
    localparam int TIMEOUT_BIT = 10;
    localparam int LOADED_BIT  = 9;
    localparam int ADDR_MSB    = 8;
    localparam int DATA_MSB    = 7;

    // reset values
    localparam logic [8:0] ADDR_RST = 9'h000;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [2:0] CMD_RST  = 3'h0;

    // valid image marker in the first memory location
    localparam logic [7:0] IMAGE_SIG = 8'hA5;

    // serial frame: start bit, 2-bit opcode, 9 address bits, 8 data bits
    localparam int         FRAME_W   = 20;
    localparam logic [4:0] LEN_SHORT = 5'h0C;
    localparam logic [4:0] LEN_LONG  = 5'h14;

    typedef logic [2:0] rsc_cmd_t;

    localparam rsc_cmd_t CMD_READ       = 3'h0;
    localparam rsc_cmd_t CMD_WR_LOCK    = 3'h1;
    localparam rsc_cmd_t CMD_WR_UNLOCK  = 3'h2;
    localparam rsc_cmd_t CMD_WRITE      = 3'h3;
    localparam rsc_cmd_t CMD_WRITE_ALL  = 3'h4;
    localparam rsc_cmd_t CMD_ERASE      = 3'h5;
    localparam rsc_cmd_t CMD_ERASE_ALL  = 3'h6;
    localparam rsc_cmd_t CMD_REFETCH    = 3'h7;

    // only programming commands poll the memory ready line
    function automatic logic may_time_out(rsc_cmd_t c);
        return (c == CMD_WRITE) || (c == CMD_WRITE_ALL) ||
               (c == CMD_ERASE) || (c == CMD_ERASE_ALL);
    endfunction

    function automatic logic [4:0] frame_len(rsc_cmd_t c);
        return (c == CMD_READ || c == CMD_REFETCH || c == CMD_WRITE ||
                c == CMD_WRITE_ALL) ? LEN_LONG : LEN_SHORT;
    endfunction

    // frame left aligned, sent msb first
    function automatic logic [19:0] build_frame(rsc_cmd_t c, logic [8:0] a, logic [7:0] d);
        logic [19:0] f;
        f = 20'h00000;
        case (c)
            CMD_READ:      f = {3'h6, a, 8'h00};
            CMD_REFETCH:   f = {3'h6, 9'h000, 8'h00};
            CMD_WRITE:     f = {3'h5, a, d};
            CMD_ERASE:     f = {3'h7, a, 8'h00};
            CMD_WR_UNLOCK: f = {3'h4, 9'h180, 8'h00};
            CMD_WR_LOCK:   f = {3'h4, 9'h000, 8'h00};
            CMD_WRITE_ALL: f = {3'h4, 9'h080, d};
            CMD_ERASE_ALL: f = {3'h4, 9'h100, 8'h00};
            default:       f = 20'h00000;
        endcase
        return f;
    endfunction

endpackage

`default_nettype wire

// ### rsc_eng_if.sv
`default_nettype none

interface rsc_eng_if;
    logic        start;
    logic [19:0] frame;
    logic [4:0]  nbits;
    logic        wait_ready;
    logic        done;
    logic        timed_out;
    logic [7:0]  rx_byte;

    modport ctrl (
        output start,
        output frame,
        output nbits,
        output wait_ready,
        input  done,
        input  timed_out,
        input  rx_byte
    );

    modport engine (
        input  start,
        input  frame,
        input  nbits,
        input  wait_ready,
        output done,
        output timed_out,
        output rx_byte
    );
endinterface

`default_nettype wire

// ### rsc_shift_engine.sv
`default_nettype none

module rsc_shift_engine #(
    parameter int unsigned TIMEOUT_CYCLES = rsc_pkg::TIMEOUT_CYC
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    rsc_eng_if.engine       eng,
    output logic            rom_select,
    output logic            rom_serial_clock,
    output logic            rom_serial_output_line,
    input  wire logic       rom_serial_input_line
);
    localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
    localparam int DW = $clog2(rsc_pkg::SK_HALF_CYC + 1);
    localparam logic [TW-1:0] TMO_LAST  = TW'(TIMEOUT_CYCLES - 1);
    localparam logic [DW-1:0] HALF_LAST = DW'(rsc_pkg::SK_HALF_CYC - 1);

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_SHIFT = 4'b0010,
        ST_GAP   = 4'b0100,
        ST_POLL  = 4'b1000
    } rsc_eng_state_e;

    rsc_eng_state_e state_q;
    logic [19:0]    frame_q;
    logic [4:0]     left_q;
    logic [DW-1:0]  div_q;
    logic [TW-1:0]  tmo_q;
    logic [7:0]     rx_q;
    logic           sk_q;
    logic           cs_q;
    logic           wait_q;
    logic           done_q;
    logic           tout_q;

    wire half      = (div_q == HALF_LAST);
    wire last_bit  = (left_q == 5'h01);
    wire tmo_hit   = (tmo_q == TMO_LAST);

    assign rom_select             = cs_q;
    assign rom_serial_clock       = sk_q;
    assign rom_serial_output_line = frame_q[rsc_pkg::FRAME_W-1];
    assign eng.done               = done_q;
    assign eng.timed_out          = tout_q;
    assign eng.rx_byte            = rx_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            frame_q <= 20'h00000;
            left_q  <= 5'h00;
            div_q   <= '0;
            tmo_q   <= '0;
            rx_q    <= 8'h00;
            sk_q    <= 1'b0;
            cs_q    <= 1'b0;
            wait_q  <= 1'b0;
            done_q  <= 1'b0;
            tout_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            div_q  <= half ? '0 : div_q + DW'(1);
            case (state_q)
                ST_IDLE: begin
                    div_q <= '0;
                    if (eng.start) begin
                        frame_q <= eng.frame;
                        left_q  <= eng.nbits;
                        wait_q  <= eng.wait_ready;
                        cs_q    <= 1'b1;
                        sk_q    <= 1'b0;
                        tout_q  <= 1'b0;
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (half) begin
                        sk_q <= ~sk_q;
                        // falling edge: advance output, capture input
                        if (sk_q) begin
                            frame_q <= {frame_q[18:0], 1'b0};
                            rx_q    <= {rx_q[6:0], rom_serial_input_line};
                            left_q  <= left_q - 5'h01;
                            if (last_bit) begin
                                cs_q <= 1'b0;
                                if (wait_q) begin
                                    state_q <= ST_GAP;
                                end else begin
                                    done_q  <= 1'b1;
                                    state_q <= ST_IDLE;
                                end
                            end
                        end
                    end
                end
                ST_GAP: begin
                    // deselect pulse so the memory drives its ready status
                    if (half) begin
                        cs_q    <= 1'b1;
                        tmo_q   <= '0;
                        state_q <= ST_POLL;
                    end
                end
                ST_POLL: begin
                    if (rom_serial_input_line) begin
                        cs_q    <= 1'b0;
                        done_q  <= 1'b1;
                        state_q <= ST_IDLE;
                    end else if (tmo_hit) begin
                        cs_q    <= 1'b0;
                        done_q  <= 1'b1;
                        tout_q  <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        tmo_q <= tmo_q + TW'(1);
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule // rsc_shift_engine

`default_nettype wire

// ### rsc_properties.sv
`default_nettype none

module rsc_properties #(
    parameter int unsigned TIMEOUT_CYCLES = 200
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rom_select,
    input wire logic        rom_serial_clock,
    input wire logic        rom_serial_output_line,
    input wire logic        rom_serial_input_line
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [31:0] poll_q;
    wire         acc    = psel && penable;
    wire         at_cmd = paddr == rsc_pkg::CMD_STATUS_OFF;
    wire         at_dat = paddr == rsc_pkg::DATA_BYTE_OFF;
    wire         sck    = rom_serial_clock;
    wire         sdo    = rom_serial_output_line;

    // select held with the clock parked: a ready poll
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) poll_q <= 32'h0;
        else if (!rom_select || sck) poll_q <= 32'h0;
        else poll_q <= poll_q + 32'h1;
    end

    // half period is 1 us: 50 cycles of the 20 ns clock
    sequence s_high_half;
        sck ##49 sck ##1 !sck;
    endsequence

    a_poll_bounded: assert property (poll_q <= TIMEOUT_CYCLES + 4)
        else $error("ready poll outlived the time-out");
    a_half_period: assert property ($rose(sck) |-> s_high_half)
        else $error("serial clock high half is not 50 cycles");
    a_out_steady: assert property (sck |=> !sck || $stable(sdo))
        else $error("serial data moved while clock high");
    a_clock_framed: assert property (sck |-> rom_select)
        else $error("serial clock outside a frame");
    a_unmapped_err: assert property (acc && !pwrite && !at_cmd && !at_dat |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_ok: assert property (acc && (at_cmd || at_dat) |-> !pslverr)
        else $error("mapped access flagged as error");
    a_data_upper: assert property (acc && !pwrite && at_dat |-> prdata[31:8] == 24'h0)
        else $error("data register upper bits not zero");
    a_cmd_reserved: assert property (acc && !pwrite && at_cmd |-> prdata[27:11] == 17'h0)
        else $error("command register reserved bits not zero");
endmodule // rsc_properties

bind rsc_top rsc_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (.*);

`default_nettype wire

// ### rsc_rom_model.sv
`default_nettype none

module rsc_rom_model (
    input  wire logic       pclk,
    input  wire logic       rom_select,
    input  wire logic       rom_serial_clock,
    input  wire logic       rom_serial_output_line,
    output logic            rom_serial_input_line,
    input  wire logic [1:0] mode,
    input  wire logic [7:0] busy_cyc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [512];
    logic [19:0] sh = 20'h0;
    logic [4:0]  n = 5'h0;
    logic [4:0]  op;
    logic [8:0]  a;
    logic [7:0]  cnt = 8'h0, rbyte = 8'h0, d;
    logic        wen = 1'b0, prog = 1'b0, drv = 1'b0, flip = 1'b0;

    // blank part except the image marker; powers up write-locked
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        mem[0] = 8'hA5;
    end
    always @(posedge pclk) begin
        flip <= ~flip;
        if (rom_select && prog && cnt != busy_cyc) cnt <= cnt + 8'h1;
    end
    always @(posedge rom_select) begin
        n = 5'h0;
        cnt = 8'h0;
    end
    always @(posedge rom_serial_clock) if (rom_select) begin
        sh = {sh[18:0], rom_serial_output_line};
        n = n + 5'h1;
        if (n == 5'h0C) rbyte = mem[sh[8:0]];
        if (n > 5'h0C) begin
            drv = rbyte[7];
            rbyte = {rbyte[6:0], 1'b0};
        end
    end
    // frame decoded when select drops; a frame with no clocks ends a poll
    always @(negedge rom_select) begin
        op = (n == 5'h14) ? sh[19:15] : sh[11:7];
        a = (n == 5'h14) ? sh[16:8] : sh[8:0];
        d = (n == 5'h14) ? sh[7:0] : 8'hFF;
        if (n == 5'h0) prog = 1'b0;
        else if (op[3:2] == 2'h0 && op[1] == op[0]) wen = op[1];
        else if (op[3:2] != 2'h2) begin
            prog = 1'b1;
            for (int i = 0; i < 512; i++)
                if (wen && (op[3:2] == 2'h0 || i == a)) mem[i] = d;
        end
    end
    // released line toggles so a stale level is never mistaken for data
    always_comb begin
        if (mode == 2'h1) rom_serial_input_line = 1'b1;
        else if (mode == 2'h2) rom_serial_input_line = 1'b0;
        else if (!rom_select) rom_serial_input_line = flip;
        else if (prog) rom_serial_input_line = (cnt == busy_cyc);
        else rom_serial_input_line = drv;
    end
endmodule // rsc_rom_model

`default_nettype wire

// ### serial_eeprom_command_controller_tb.sv
`default_nettype none

module serial_eeprom_command_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] CMD = rsc_pkg::CMD_STATUS_OFF;
    localparam logic [11:0] DAT = rsc_pkg::DATA_BYTE_OFF;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, rom_select, rom_serial_clock, rom_serial_output_line;
    logic        rom_serial_input_line, err, ld = 1'b1;
    logic [1:0]  mode = 2'h0;
    logic [7:0]  busy_cyc = 8'h28;
    int          miscompares = 0, n_checks = 0, cyc = 0;

    always #10 pclk = ~pclk;
    rsc_top #(.TIMEOUT_CYCLES(200)) dut (.*);
    rsc_rom_model u_rom (.*);

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_idle(output logic [31:0] r);
        int k;
        k = 0;
        do begin
            apb(1'b0, CMD, 32'h0, r);
            k++;
        end while (r[31] !== 1'b0 && k < 3000);
    endtask
    // start a command, wait for busy to drop, judge the status word
    task automatic run(input logic [2:0] c, input logic [8:0] a, input logic to);
        logic [31:0] r;
        apb(1'b1, CMD, {1'b1, c, 19'h0, a}, r);
        wait_idle(r);
        chk(r, {1'b0, c, 17'h0, to, ld, a});
        if (to) begin
            apb(1'b1, CMD, 32'h400, r);
            apb(1'b0, CMD, 32'h0, r);
            chk(r, {22'h0, ld, 9'h0});
        end
    endtask

    task automatic t_boot();
        logic [31:0] r;
        apb(1'b0, CMD, 32'h0, r);
        chk(r, 32'h80000000);
        wait_idle(r);
        chk(r, 32'h00000200);
        apb(1'b0, DAT, 32'h0, r);
        chk(r, 32'h0);
        apb(1'b1, 12'h038, 32'hFFFFFFFF, r);
        apb(1'b0, 12'h038, 32'h0, r);
        chk({r[31:1], err}, 32'h1);
    endtask
    task automatic t_prog();
        logic [31:0] r;
        run(3'h2, 9'h000, 1'b0);
        apb(1'b1, DAT, 32'hFFFFFF3C, r);
        apb(1'b1, CMD, {1'b1, 3'h3, 19'h0, 9'h1A5}, r);
        apb(1'b1, DAT, 32'h55, r);
        wait_idle(r);
        apb(1'b0, DAT, 32'h0, r);
        chk(r, 32'h3C);
        chk({24'h0, u_rom.mem[9'h1A5]}, 32'h3C);
        apb(1'b1, DAT, 32'h0, r);
        run(3'h0, 9'h1A5, 1'b0);
        apb(1'b0, DAT, 32'h0, r);
        chk(r, 32'h3C);
        busy_cyc <= 8'h02;
        apb(1'b1, DAT, 32'h77, r);
        run(3'h4, 9'h000, 1'b0);
        run(3'h5, 9'h0FF, 1'b0);
        chk({16'h0, u_rom.mem[9'h0FF], u_rom.mem[9'h100]}, 32'hFF77);
        run(3'h6, 9'h000, 1'b0);
        chk({24'h0, u_rom.mem[9'h100]}, 32'hFF);
        apb(1'b1, CMD, 32'h200, r);
        ld = 1'b0;
        run(3'h7, 9'h000, 1'b0);
        apb(1'b0, DAT, 32'h0, r);
        chk(r, 32'h77);
        apb(1'b1, DAT, 32'hA5, r);
        run(3'h3, 9'h000, 1'b0);
        ld = 1'b1;
        run(3'h7, 9'h000, 1'b0);
        run(3'h1, 9'h000, 1'b0);
        apb(1'b1, DAT, 32'h11, r);
        run(3'h3, 9'h002, 1'b0);
        chk({24'h0, u_rom.mem[9'h002]}, 32'hFF);
    endtask
    // no memory fitted: line held low, then held high
    task automatic t_absent();
        mode <= 2'h2;
        for (int c = 0; c < 8; c++) run(3'(c), 9'h011, c >= 3 && c <= 6);
        mode <= 2'h1;
        for (int c = 0; c < 8; c++) run(3'(c), 9'h011, 1'b0);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_boot();
        t_prog();
        t_absent();
        finish_test();
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 90000) begin
            miscompares++;
            finish_test();
        end
    end
endmodule // serial_eeprom_command_controller_tb

`default_nettype wire
